// *** fsp_pkg.sv ***
// Package of constants and types for the flash self-program register block
package fsp_pkg;

    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [11:0] ADDR_DATA_LOW = 12'h000;
    localparam logic [11:0] ADDR_DATA_HIGH = 12'h004;
    localparam logic [11:0] ADDR_ADDRESS_LOW = 12'h008;
    localparam logic [11:0] ADDR_ADDRESS_HIGH = 12'h00c;
    localparam logic [11:0] ADDR_CONTROL_ONE = 12'h010;
    localparam logic [11:0] ADDR_UNLOCK = 12'h014;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int CTL_READ_START = 0;
    localparam int CTL_WRITE_START = 1;
    localparam int CTL_PROGRAM_ENABLE = 2;
    localparam int CTL_WRITE_ERROR = 3;
    localparam int CTL_ERASE_ENABLE = 4;
    localparam int CTL_LATCH_ONLY = 5;
    localparam int CTL_REGION_SELECT = 6;

    // ----------------------------------------------------------------
    // Values and counts
    // ----------------------------------------------------------------
    localparam logic [7:0] UNLOCK_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND = 8'haa;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [13:0] LATCH_RESET_WORD = 14'h3fff;
    localparam logic [13:0] ERASED_WORD = 14'h3fff;
    localparam int ROW_WORDS = 32;
    localparam int CLK_FREQ_HZ = 10_000_000;
    localparam int ARRAY_OP_TIME_US = 2;
    localparam int ARRAY_OP_CYCLES = (ARRAY_OP_TIME_US * (CLK_FREQ_HZ / 1_000_000));
    localparam logic [7:0] ARRAY_OP_COUNT = 8'(ARRAY_OP_CYCLES);

    typedef enum logic [1:0] {
        CMD_LATCH,
        CMD_ERASE,
        CMD_PROGRAM
    } fsp_cmd_e;

endpackage : fsp_pkg

// *** fsp_array_if.sv ***
// Interface between register front end and the flash array model
`timescale 1ns/1ps
interface fsp_array_if;
    logic start;
    fsp_pkg::fsp_cmd_e cmd;
    logic region;
    logic [14:0] addr;
    logic [13:0] wdata;
    logic rd_start;
    logic busy;
    logic done;
    logic [13:0] rdata;

    modport ctrl (output start, cmd, region, addr, wdata, rd_start, input busy, done, rdata);
    modport array (input start, cmd, region, addr, wdata, rd_start, output busy, done, rdata);
endinterface : fsp_array_if

// *** fsp_array.sv ***
// Flash row array with write latches, erase and program sequencing
`timescale 1ns/1ps
module fsp_array (
    input wire logic i_clk,
    input wire logic i_rst,
    fsp_array_if.array bus
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    // Kept small: 4 rows of main flash, one of configuration space
    logic [13:0] mem_q [0:(5*fsp_pkg::ROW_WORDS)-1];
    logic [13:0] latch_q [0:fsp_pkg::ROW_WORDS-1];
    logic [7:0] cnt_q;
    logic busy_q;
    logic done_q;
    fsp_pkg::fsp_cmd_e cmd_q;
    logic [7:0] row_base_q;
    logic [13:0] rdata_q;
    logic [7:0] word_idx;
    logic [7:0] row_idx;

    // Configuration region is folded onto the last row
    always_comb begin
        row_idx = bus.region ? 8'h04 : {6'h00, bus.addr[6:5]};
        word_idx = {row_idx[2:0], bus.addr[4:0]};
    end

    assign bus.busy = busy_q;
    assign bus.done = done_q;
    assign bus.rdata = rdata_q;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            cnt_q <= 8'h00;
            cmd_q <= fsp_pkg::CMD_LATCH;
            row_base_q <= 8'h00;
        end else begin
            done_q <= 1'b0;
            if (bus.start && !busy_q) begin
                busy_q <= 1'b1;
                cmd_q <= bus.cmd;
                row_base_q <= {row_idx[2:0], 5'h00};
                cnt_q <= (bus.cmd == fsp_pkg::CMD_LATCH) ? 8'h01 : fsp_pkg::ARRAY_OP_COUNT;
            end else if (busy_q) begin
                if (cnt_q == 8'h01) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Latches and array contents
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            for (int i = 0; i < fsp_pkg::ROW_WORDS; i++) begin
                latch_q[i] <= fsp_pkg::LATCH_RESET_WORD;
            end
        end else if (bus.start && !busy_q && bus.cmd == fsp_pkg::CMD_LATCH) begin
            latch_q[bus.addr[4:0]] <= bus.wdata;
        end else if (busy_q && cnt_q == 8'h01 && cmd_q == fsp_pkg::CMD_PROGRAM) begin
            for (int i = 0; i < fsp_pkg::ROW_WORDS; i++) begin
                latch_q[i] <= fsp_pkg::LATCH_RESET_WORD;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (busy_q && cnt_q == 8'h01) begin
            for (int i = 0; i < fsp_pkg::ROW_WORDS; i++) begin
                if (cmd_q == fsp_pkg::CMD_ERASE) begin
                    mem_q[row_base_q + 8'(i)] <= fsp_pkg::ERASED_WORD;
                end else if (cmd_q == fsp_pkg::CMD_PROGRAM) begin
                    mem_q[row_base_q + 8'(i)] <= mem_q[row_base_q + 8'(i)] & latch_q[i];
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_q <= 14'h0000;
        end else if (bus.rd_start) begin
            rdata_q <= mem_q[word_idx];
        end
    end

endmodule : fsp_array

// *** fsp_regs.sv ***
// APB register front end of the flash self-program controller
//
// Functional notes
// - Data low byte read/write, unknown at power-up
// - Data high bits 5:0 read/write
// - Data high bits 7:6 read zero
// - Address low byte read/write, resets zero
// - Address high bits 6:0 read/write, reset zero
// - Address high bit 7 reads one
// - Top address bit undefined during write
// - Region select picks flash or configuration
// - Write needs 55h then AAh unlock
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module fsp_regs (
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR
);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [7:0] data_low_q;
    logic [5:0] data_high_q;
    logic [7:0] addr_low_q;
    logic [6:0] addr_high_q;
    logic region_q;
    logic latch_only_q;
    logic erase_q;
    logic error_q;
    logic enable_q;
    logic write_q;
    logic read_q;
    logic read_busy_q;
    logic [1:0] unlock_q;
    logic [31:0] prdata_q;
    logic [7:0] ctl_rd;
    logic [31:0] rd_d;
    logic wr_acc;
    logic rd_acc;
    logic mapped;
    logic wr_lane0;
    logic set_write;
    logic set_read;
    logic wr_data_low;
    logic wr_data_high;
    logic wr_addr_low;
    logic wr_addr_high;
    logic wr_control;
    logic wr_unlock;
    logic start_ok;
    logic start_refused;

    fsp_array_if arr ();

    fsp_array u_array (
        .i_clk(I_CORE_CLK),
        .i_rst(I_RST),
        .bus(arr)
    );

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // Zero wait states; unmapped addresses answer with an error
    assign O_PREADY = 1'b1;
    assign wr_acc = I_PSEL && I_PENABLE && I_PWRITE;
    assign rd_acc = I_PSEL && I_PENABLE && !I_PWRITE;
    assign wr_lane0 = wr_acc && I_PSTRB[0];
    assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;
    assign O_PRDATA = prdata_q;

    always_comb begin
        case (I_PADDR)
            fsp_pkg::ADDR_DATA_LOW, fsp_pkg::ADDR_DATA_HIGH, fsp_pkg::ADDR_ADDRESS_LOW,
            fsp_pkg::ADDR_ADDRESS_HIGH, fsp_pkg::ADDR_CONTROL_ONE, fsp_pkg::ADDR_UNLOCK: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Register write strobes
    // ----------------------------------------------------------------
    // Only byte lane 0 carries register bits, so a write without it changes no register
    assign wr_data_low = wr_lane0 && I_PADDR == fsp_pkg::ADDR_DATA_LOW;
    assign wr_data_high = wr_lane0 && I_PADDR == fsp_pkg::ADDR_DATA_HIGH;
    assign wr_addr_low = wr_lane0 && I_PADDR == fsp_pkg::ADDR_ADDRESS_LOW;
    assign wr_addr_high = wr_lane0 && I_PADDR == fsp_pkg::ADDR_ADDRESS_HIGH;
    assign wr_control = wr_lane0 && I_PADDR == fsp_pkg::ADDR_CONTROL_ONE;
    assign wr_unlock = wr_lane0 && I_PADDR == fsp_pkg::ADDR_UNLOCK;

    // ----------------------------------------------------------------
    // Data and address registers
    // ----------------------------------------------------------------
    // Data bytes are not reset: their value is unknown until written or read back
    always_ff @(posedge I_CORE_CLK) begin
        if (read_busy_q && !I_RST) begin
            data_low_q <= arr.rdata[7:0];
        end else if (wr_data_low) begin
            data_low_q <= I_PWDATA[7:0];
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (read_busy_q && !I_RST) begin
            data_high_q <= arr.rdata[13:8];
        end else if (wr_data_high) begin
            data_high_q <= I_PWDATA[5:0];
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            addr_low_q <= fsp_pkg::RESET_BYTE;
        end else if (wr_addr_low) begin
            addr_low_q <= I_PWDATA[7:0];
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            addr_high_q <= fsp_pkg::RESET_BYTE[6:0];
        end else if (wr_addr_high) begin
            addr_high_q <= I_PWDATA[6:0];
        end
    end

    // ----------------------------------------------------------------
    // Unlock sequence
    // ----------------------------------------------------------------
    // Any other access in between breaks the sequence
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            unlock_q <= 2'b00;
        end else if (wr_unlock) begin
            if (I_PWDATA[7:0] == fsp_pkg::UNLOCK_FIRST) begin
                unlock_q <= 2'b01;
            end else if (I_PWDATA[7:0] == fsp_pkg::UNLOCK_SECOND && unlock_q == 2'b01) begin
                unlock_q <= 2'b10;
            end else begin
                unlock_q <= 2'b00;
            end
        end else if (I_PSEL && I_PENABLE && unlock_q != 2'b00 &&
                     !(wr_acc && I_PADDR == fsp_pkg::ADDR_CONTROL_ONE)) begin
            unlock_q <= 2'b00;
        end else if (wr_acc && I_PADDR == fsp_pkg::ADDR_CONTROL_ONE) begin
            unlock_q <= 2'b00;
        end
    end

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    assign set_write = wr_control && I_PWDATA[fsp_pkg::CTL_WRITE_START] && !write_q && !read_busy_q;
    assign set_read = wr_control && I_PWDATA[fsp_pkg::CTL_READ_START] && !write_q && !read_q;
    assign start_ok = set_write && enable_q && unlock_q == 2'b10;
    // A start refused after a partial or unenabled unlock is flagged; one after no unlock or a broken one is not flagged
    assign start_refused = set_write && !start_ok && unlock_q != 2'b00;

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            region_q <= 1'b0;
            latch_only_q <= 1'b0;
            erase_q <= 1'b0;
        end else if (wr_control) begin
            region_q <= I_PWDATA[fsp_pkg::CTL_REGION_SELECT];
            latch_only_q <= I_PWDATA[fsp_pkg::CTL_LATCH_ONLY];
            erase_q <= I_PWDATA[fsp_pkg::CTL_ERASE_ENABLE];
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            enable_q <= 1'b0;
        end else if (wr_control) begin
            enable_q <= I_PWDATA[fsp_pkg::CTL_PROGRAM_ENABLE];
        end
    end

    // Write start: set only with enable and a complete unlock, cleared at completion
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            write_q <= 1'b0;
        end else if (start_ok) begin
            write_q <= 1'b1;
        end else if (arr.done) begin
            write_q <= 1'b0;
        end
    end

    // Read start takes one cycle of the array and then clears itself
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            read_q <= 1'b0;
        end else begin
            read_q <= set_read;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            read_busy_q <= 1'b0;
        end else begin
            read_busy_q <= read_q;
        end
    end

    // Error flag: hardware set wins over a software clear in the same cycle
    // A one-cycle reset that cuts a running write leaves the flag set; a longer reset clears it
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            error_q <= write_q;
        end else if (start_refused) begin
            error_q <= 1'b1;
        end else if (wr_control) begin
            error_q <= I_PWDATA[fsp_pkg::CTL_WRITE_ERROR];
        end
    end

    // ----------------------------------------------------------------
    // Array command
    // ----------------------------------------------------------------
    logic write_prev_q;

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            write_prev_q <= 1'b0;
        end else begin
            write_prev_q <= write_q;
        end
    end

    always_comb begin
        arr.start = write_q && !write_prev_q;
        arr.rd_start = read_q;
        arr.region = region_q;
        arr.addr = {addr_high_q, addr_low_q};
        arr.wdata = {data_high_q, data_low_q};
        if (erase_q) begin
            arr.cmd = fsp_pkg::CMD_ERASE;
        end else if (latch_only_q) begin
            arr.cmd = fsp_pkg::CMD_LATCH;
        end else begin
            arr.cmd = fsp_pkg::CMD_PROGRAM;
        end
    end

    // ----------------------------------------------------------------
    // Read back
    // ----------------------------------------------------------------
    always_comb begin
        ctl_rd = 8'h00;
        ctl_rd[fsp_pkg::CTL_REGION_SELECT] = region_q;
        ctl_rd[fsp_pkg::CTL_LATCH_ONLY] = latch_only_q;
        ctl_rd[fsp_pkg::CTL_ERASE_ENABLE] = erase_q;
        ctl_rd[fsp_pkg::CTL_WRITE_ERROR] = error_q;
        ctl_rd[fsp_pkg::CTL_PROGRAM_ENABLE] = enable_q;
        ctl_rd[fsp_pkg::CTL_WRITE_START] = write_q;
        ctl_rd[fsp_pkg::CTL_READ_START] = read_q;
        case (I_PADDR)
            fsp_pkg::ADDR_DATA_LOW: begin
                rd_d = {24'h000000, data_low_q};
            end
            fsp_pkg::ADDR_DATA_HIGH: begin
                rd_d = {24'h000000, 2'b00, data_high_q};
            end
            fsp_pkg::ADDR_ADDRESS_LOW: begin
                rd_d = {24'h000000, addr_low_q};
            end
            fsp_pkg::ADDR_ADDRESS_HIGH: begin
                // Top bit is shown as one even during a write, allowed since it is undefined then
                rd_d = {24'h000000, 1'b1, addr_high_q};
            end
            fsp_pkg::ADDR_CONTROL_ONE: begin
                rd_d = {24'h000000, ctl_rd};
            end
            default: begin
                rd_d = 32'h00000000;
            end
        endcase
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            prdata_q <= 32'h00000000;
        end else if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
            prdata_q <= rd_d;
        end
    end

    logic unused_rd;
    assign unused_rd = rd_acc | arr.busy;

endmodule : fsp_regs

// *** fsp_regs_props.sv ***
// Port checker of the flash self-program register block
`timescale 1ns/1ps
module fsp_regs_props (
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    input wire logic [31:0] O_PRDATA,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR
);
    // ----------------
    // Bus decode and shadows
    // ----------------
    localparam logic [11:0] CTL = fsp_pkg::ADDR_CONTROL_ONE;
    logic acc, su, wr, wst, refuse;
    logic [1:0] ulk_q;
    logic pe_q, busy_q, dv_q;
    logic [7:0] al_q, dl_q;
    logic [6:0] ah_q;
    logic [5:0] dh_q;
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);
    assign acc = I_PSEL && I_PENABLE;
    assign su = I_PSEL && !I_PENABLE && !I_PWRITE;
    assign wr = acc && I_PWRITE && I_PSTRB[0];
    assign wst = wr && I_PADDR == CTL && I_PWDATA[1];
    assign refuse = wst && !(ulk_q == 2'd2 && pe_q) && !busy_q;
    // Any other access in between breaks the unlock pair
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            ulk_q <= 2'd0;
        end else if (acc) begin
            ulk_q <= !(wr && I_PADDR == fsp_pkg::ADDR_UNLOCK) ? 2'd0 :
                (I_PWDATA[7:0] == fsp_pkg::UNLOCK_FIRST) ? 2'd1 :
                (I_PWDATA[7:0] == fsp_pkg::UNLOCK_SECOND && ulk_q == 2'd1) ? 2'd2 : 2'd0;
        end
    end
    // Busy is set by an accepted start; its end is only known from what a control read shows
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            busy_q <= 1'b0;
        end else if (wst && !refuse) begin
            busy_q <= 1'b1;
        end else if ($past(su) && $past(I_PADDR) == CTL && !O_PRDATA[1]) begin
            busy_q <= 1'b0;
        end
    end
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            al_q <= 8'h00;
            ah_q <= 7'h00;
            pe_q <= 1'b0;
            dv_q <= 1'b0;
        end else if (wr) begin
            if (I_PADDR == fsp_pkg::ADDR_ADDRESS_LOW) al_q <= I_PWDATA[7:0];
            if (I_PADDR == fsp_pkg::ADDR_ADDRESS_HIGH) ah_q <= I_PWDATA[6:0];
            if (I_PADDR == fsp_pkg::ADDR_DATA_LOW) dl_q <= I_PWDATA[7:0];
            if (I_PADDR == fsp_pkg::ADDR_DATA_HIGH) dh_q <= I_PWDATA[5:0];
            if (I_PADDR == fsp_pkg::ADDR_DATA_HIGH) dv_q <= 1'b1;
            if (I_PADDR == CTL) pe_q <= I_PWDATA[2];
            if (I_PADDR == CTL && I_PWDATA[0]) dv_q <= 1'b0;
        end
    end
    // ----------------
    // Properties
    // ----------------
    property p_dl;
        su && I_PADDR == fsp_pkg::ADDR_DATA_LOW && dv_q |=> O_PRDATA[7:0] == dl_q;
    endproperty
    property p_dh;
        su && I_PADDR == fsp_pkg::ADDR_DATA_HIGH && dv_q |=> O_PRDATA[5:0] == dh_q;
    endproperty
    property p_dh_top;
        su && I_PADDR == fsp_pkg::ADDR_DATA_HIGH |=> O_PRDATA[7:6] == 2'b00;
    endproperty
    property p_al;
        su && I_PADDR == fsp_pkg::ADDR_ADDRESS_LOW |=> O_PRDATA[7:0] == al_q;
    endproperty
    property p_ah;
        su && I_PADDR == fsp_pkg::ADDR_ADDRESS_HIGH |=> O_PRDATA[6:0] == ah_q;
    endproperty
    property p_ah_top;
        su && I_PADDR == fsp_pkg::ADDR_ADDRESS_HIGH && !busy_q |=> O_PRDATA[7];
    endproperty
    property p_refuse;
        refuse ##2 (su && I_PADDR == CTL) |=> !O_PRDATA[1];
    endproperty
    property p_rd_clear;
        (wr && I_PADDR == CTL && I_PWDATA[0]) ##2 (su && I_PADDR == CTL) |=> !O_PRDATA[0];
    endproperty
    a_dl: assert property (p_dl) else $error("data low readback wrong");
    a_dh: assert property (p_dh) else $error("data high readback wrong");
    a_dh_top: assert property (p_dh_top) else $error("data high top bits not zero");
    a_al: assert property (p_al) else $error("address low readback wrong");
    a_ah: assert property (p_ah) else $error("address high readback wrong");
    a_ah_top: assert property (p_ah_top) else $error("address high top bit not one");
    a_refuse: assert property (p_refuse) else $error("write started without unlock");
    a_rd_clear: assert property (p_rd_clear) else $error("read start not cleared");
    c_refuse: cover property (refuse);
    c_start: cover property (wst && !refuse);
    c_slverr: cover property (acc && O_PSLVERR);
endmodule : fsp_regs_props
bind fsp_regs fsp_regs_props props_u (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .I_PSTRB(I_PSTRB), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR));

// *** fsp_regs_test.sv ***
// Self-checking bench of the flash self-program register block
`timescale 1ns/1ps
module fsp_regs_test;
    localparam logic [11:0] DL = fsp_pkg::ADDR_DATA_LOW;
    localparam logic [11:0] DH = fsp_pkg::ADDR_DATA_HIGH;
    localparam logic [11:0] AL = fsp_pkg::ADDR_ADDRESS_LOW;
    localparam logic [11:0] AH = fsp_pkg::ADDR_ADDRESS_HIGH;
    localparam logic [11:0] CTL = fsp_pkg::ADDR_CONTROL_ONE;
    localparam logic [11:0] UNL = fsp_pkg::ADDR_UNLOCK;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] padr = 12'h000;
    logic [31:0] pwd = 32'h0;
    logic [3:0] pstb = 4'h0;
    logic [31:0] prd, rv;
    logic rdy, err, ev;
    int bad_count = 0;
    int checks = 0;
    always #50 clk = ~clk;
    fsp_regs dut_u (.I_CORE_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(padr), .I_PWDATA(pwd), .I_PSTRB(pstb), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(err));
    // ----------------
    // Shared tasks
    // ----------------
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= {24'h0, d};
        pstb <= s;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        rv = prd;
        ev = err;
        if (n >= 20) begin
            bad_count++;
            give_verdict();
        end
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic wrt(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 4'h1);
    endtask : wrt
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 8'h00, 4'h0);
    endtask : rd
    // Unlocked start, then poll until the start bit drops
    task automatic op(input logic [7:0] c);
        int n = 0;
        wrt(CTL, c);
        wrt(UNL, 8'h55);
        wrt(UNL, 8'haa);
        wrt(CTL, c | 8'h02);
        do begin
            rd(CTL);
            n++;
        end while (rv[1] !== 1'b0 && n < 100);
        chk(rv & 32'h2, 32'h0);
        if (rv[1] !== 1'b0) begin
            give_verdict();
        end
    endtask : op
    task automatic rword(input logic [7:0] c, input logic [14:0] a, input logic [13:0] e);
        logic [7:0] lo;
        wrt(AL, a[7:0]);
        wrt(AH, {1'b0, a[14:8]});
        wrt(CTL, c | 8'h01);
        rd(CTL);
        chk(rv & 32'h1, 32'h0);
        rd(DL);
        lo = rv[7:0];
        rd(DH);
        chk({rv[23:0], lo}, {18'h0, e});
    endtask : rword
    // ----------------
    // Scenarios
    // ----------------
    task automatic t_reset;
        rd(AL);
        chk(rv, 32'h00);
        rd(AH);
        chk(rv, 32'h80);
        rd(CTL);
        chk(rv, 32'h00);
        chk({31'h0, rdy}, 32'h1);
        $display("test reset done");
    endtask : t_reset
    task automatic t_regs;
        wrt(DL, 8'ha5);
        wrt(DH, 8'hff);
        wrt(AL, 8'hff);
        wrt(AH, 8'hff);
        apb(1'b1, DL, 8'h5a, 4'h0);
        rd(DL);
        chk(rv, 32'ha5);
        rd(DH);
        chk(rv, 32'h3f);
        rd(AL);
        chk(rv, 32'hff);
        rd(AH);
        chk(rv, 32'hff);
        wrt(AH, 8'h00);
        rd(AH);
        chk(rv, 32'h80);
        rd(12'h01c);
        chk({rv[30:0], ev}, 32'h1);
        $display("test registers done");
    endtask : t_regs
    // Reversed pair, interrupted pair, and a good pair without enable
    task automatic t_unlock;
        wrt(CTL, 8'h04);
        wrt(UNL, 8'haa);
        wrt(UNL, 8'h55);
        wrt(CTL, 8'h06);
        rd(CTL);
        chk(rv & 32'ha, 32'h8);
        wrt(UNL, 8'h55);
        wrt(UNL, 8'haa);
        rd(DL);
        wrt(CTL, 8'h06);
        rd(CTL);
        chk(rv & 32'ha, 32'h0);
        wrt(CTL, 8'h00);
        wrt(UNL, 8'h55);
        wrt(UNL, 8'haa);
        wrt(CTL, 8'h02);
        rd(CTL);
        chk(rv & 32'ha, 32'h8);
        $display("test unlock done");
    endtask : t_unlock
    task automatic t_ops;
        wrt(AL, 8'h03);
        wrt(AH, 8'h00);
        op(8'h14);
        rword(8'h00, 15'h0003, 14'h3fff);
        rword(8'h00, 15'h001f, 14'h3fff);
        wrt(DL, 8'h34);
        wrt(DH, 8'h12);
        wrt(AL, 8'h03);
        op(8'h24);
        rword(8'h00, 15'h0003, 14'h3fff);
        op(8'h04);
        rword(8'h00, 15'h0003, 14'h1234);
        rword(8'h00, 15'h0004, 14'h3fff);
        op(8'h54);
        rword(8'h40, 15'h0003, 14'h3fff);
        rword(8'h00, 15'h0003, 14'h1234);
        $display("test array operations done");
    endtask : t_ops
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_unlock();
        t_ops();
        give_verdict();
    end
endmodule : fsp_regs_test
